/* rtl/lpmc_top.sv */
// Decided for this implementation: the strobed register port and the address map.
`timescale 1ns/1ps
`include "lpmc_map.svh"

module lpmc_top (
  input  wire logic                 mclk_i,
  input  wire logic                 sys_rst_i,
  input  wire logic [7:0]           reg_addr_i,
  input  wire logic [7:0]           reg_wdata_i,
  input  wire logic                 reg_wr_i,
  input  wire logic                 reg_rd_i,
  output logic      [7:0]           reg_rdata_o,
  input  wire logic                 stop_exec_i,
  input  wire logic                 irq_pending_i,
  input  wire logic                 i_flag_i,
  input  wire logic                 ext_irq_zero_i,
  input  wire logic                 ext_irq_one_i,
  input  wire logic                 rc_clk_i,
  output logic                      cpu_halt_o,
  output logic                      main_osc_en_o,
  output logic                      prescaler_en_o,
  output logic                      presc_2048_only_o,
  output logic                      timer0_en_o,
  output logic                      rc_osc_en_o,
  output logic                      resume_o,
  output logic                      irq_vector_o,
  output logic                      wdt_irq_o,
  output logic                      wdt_reset_o,
  output logic                      stop_ignored_o,
  output lpmc_pkg::lpmc_mode_t      mode_o
);
  import lpmc_pkg::*;

  // --------------------------------------------------------------------------
  // Declarations
  // --------------------------------------------------------------------------
  lpmc_wdt_if wdt_bus ();

  lpmc_state_t               state_reg,   state_next;
  lpmc_mode_t                mode_reg,    mode_next;
  logic [7:0]                ccr_reg,     ccr_next;
  logic [7:0]                ieh_reg,     ieh_next;
  logic [6:0]                wdl_reg,     wdl_next;
  logic                      wclr_reg,    wclr_next;
  logic [7:0]                t0c_reg,     t0c_next;
  logic [7:0]                t1c_reg,     t1c_next;
  logic [3:0]                edge_reg,    edge_next;
  logic                      wflag_reg,   wflag_next;
  logic [7:0]                rdata_reg,   rdata_next;
  logic [3:0]                src_reg,     src_next;
  logic [`LPMC_PRESC_W-1:0]  presc_reg,   presc_next;
  logic [7:0]                bit_reg,     bit_next;
  logic [15:0]               t0_reg,      t0_next;
  logic [6:2]                pulse_reg,   pulse_next;
  logic [5:0]                en_reg,      en_next;
  logic [2:0]                pin_in;
  logic [2:0]                sync_reg [0:2];
  logic [2:0]                sync_next [0:2];
  logic [2:0]                hit;
  logic                      tick2048;
  logic                      bit_tick;
  logic                      bit_ovf;
  logic [15:0]               t0_limit;
  logic                      t0_ovf;
  logic                      wake_any;
  logic [`LPMC_PRESC_W-1:0]  bit_mask;

  // --------------------------------------------------------------------------
  // Pin synchronisers
  // --------------------------------------------------------------------------
  // Index 0 and 1 are the external interrupt pins, index 2 is the RC clock.
  // Stage 0 feeds only stage 1; edges are taken between stages 1 and 2.
  assign pin_in = {rc_clk_i, ext_irq_one_i, ext_irq_zero_i};

  genvar gi;
  generate
    for (gi = 0; gi < 3; gi = gi + 1) begin : g_sync
      always_comb begin
        sync_next[gi] = {sync_reg[gi][1:0], pin_in[gi]};
      end

      always_ff @(posedge mclk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
          sync_reg[gi] <= 3'h0;
        end else begin
          sync_reg[gi] <= sync_next[gi];
        end
      end

      if (gi < 2) begin : g_edge
        assign hit[gi] = (sync_reg[gi][1] & ~sync_reg[gi][2] & edge_reg[2*gi])
                       | (~sync_reg[gi][1] & sync_reg[gi][2] & edge_reg[2*gi+1]);
      end else begin : g_rc
        assign hit[gi] = sync_reg[gi][1] & ~sync_reg[gi][2];
      end
    end
  endgenerate

  // --------------------------------------------------------------------------
  // Timing taps
  // --------------------------------------------------------------------------
  // The interval timer tap divides by two to the power of (select + 1).
  assign bit_mask = (`LPMC_PRESC_W'(2) << ccr_reg[`LPMC_CCR_BITSEL_HI:`LPMC_CCR_BITSEL_LO])
                  - `LPMC_PRESC_W'(1);
  assign tick2048 = (presc_reg[10:0] == `LPMC_DIV2048_TOP);
  assign bit_tick = ((presc_reg & bit_mask) == bit_mask);
  assign bit_ovf  = bit_tick && (bit_reg == `LPMC_BIT_TOP);

  assign t0_limit = ccr_reg[`LPMC_CCR_CASCADE_BIT] ? {t1c_reg, t0c_reg} : {8'h00, t0c_reg};
  // Timer0 counts only the 2048 tap.
  assign t0_ovf   = (mode_reg == LPMC_MODE_WAKE) && tick2048 && (t0_reg == t0_limit);

  assign wake_any = hit[0] | hit[1] | t0_ovf
                  | (wdt_bus.match && (mode_reg == LPMC_MODE_RC_WATCHDOG_SELECT));

  // --------------------------------------------------------------------------
  // Watchdog
  // --------------------------------------------------------------------------
  // Asleep in RC mode the watchdog steps on the RC clock; running, on interval overflow; in other sleep modes and the wait, not at all.
  assign wdt_bus.tick  = (state_reg == LPMC_ST_SLEEP)
                       ? (hit[2] && (mode_reg == LPMC_MODE_RC_WATCHDOG_SELECT))
                       : ((state_reg == LPMC_ST_RUN) && bit_ovf);
  assign wdt_bus.clear = wclr_reg;
  assign wdt_bus.limit = wdl_reg;

  lpmc_watchdog u_watchdog (
    .mclk_i    (mclk_i),
    .sys_rst_i (sys_rst_i),
    .wdt       (wdt_bus.wdt)
  );

  // --------------------------------------------------------------------------
  // Register file
  // --------------------------------------------------------------------------
  always_comb begin
    ccr_next   = ccr_reg;
    ieh_next   = ieh_reg;
    wdl_next   = wdl_reg;
    wclr_next  = 1'b0;
    t0c_next   = t0c_reg;
    t1c_next   = t1c_reg;
    edge_next  = edge_reg;
    wflag_next = wflag_reg;
    rdata_next = 8'h00;
    if (reg_wr_i) begin
      unique case (reg_addr_i)
        `LPMC_OFF_CLK_CTL:   ccr_next  = reg_wdata_i;
        `LPMC_OFF_IRQ_EN_HI: ieh_next  = reg_wdata_i;
        `LPMC_OFF_WDT_DATA: begin
          wdl_next  = reg_wdata_i[6:0];
          wclr_next = reg_wdata_i[`LPMC_WDT_CLEAR_BIT];
        end
        `LPMC_OFF_T0_CMP:    t0c_next  = reg_wdata_i;
        `LPMC_OFF_T1_CMP:    t1c_next  = reg_wdata_i;
        `LPMC_OFF_EDGE_SEL:  edge_next = reg_wdata_i[3:0];
        `LPMC_OFF_STATUS: begin
          if (reg_wdata_i[`LPMC_STS_WDTFLAG_BIT]) begin
            wflag_next = 1'b0;
          end
        end
        default: ;
      endcase
    end
    // Match sets the sticky flag; set wins over clear.
    if (wdt_bus.match) begin
      wflag_next = 1'b1;
    end
    if (reg_rd_i) begin
      unique case (reg_addr_i)
        `LPMC_OFF_CLK_CTL:   rdata_next = ccr_reg;
        `LPMC_OFF_IRQ_EN_HI: rdata_next = ieh_reg;
        `LPMC_OFF_WDT_DATA:  rdata_next = {1'b0, wdl_reg};
        `LPMC_OFF_T0_CMP:    rdata_next = t0c_reg;
        `LPMC_OFF_T1_CMP:    rdata_next = t1c_reg;
        `LPMC_OFF_EDGE_SEL:  rdata_next = {4'h0, edge_reg};
        `LPMC_OFF_STATUS:    rdata_next = {1'b0, wflag_reg, mode_reg, state_reg};
        `LPMC_OFF_WAKE_SRC:  rdata_next = {4'h0, src_reg};
        default:             rdata_next = 8'h00;
      endcase
    end
  end

  always_ff @(posedge mclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      ccr_reg   <= `LPMC_RST_CLK_CTL;
      ieh_reg   <= `LPMC_RST_IRQ_EN_HI;
      wdl_reg   <= `LPMC_RST_WDT_DATA;
      wclr_reg  <= 1'b0;
      t0c_reg   <= `LPMC_RST_T0_CMP;
      t1c_reg   <= `LPMC_RST_T1_CMP;
      edge_reg  <= `LPMC_RST_EDGE_SEL;
      wflag_reg <= 1'b0;
      rdata_reg <= 8'h00;
    end else begin
      ccr_reg   <= ccr_next;
      ieh_reg   <= ieh_next;
      wdl_reg   <= wdl_next;
      wclr_reg  <= wclr_next;
      t0c_reg   <= t0c_next;
      t1c_reg   <= t1c_next;
      edge_reg  <= edge_next;
      wflag_reg <= wflag_next;
      rdata_reg <= rdata_next;
    end
  end

  // --------------------------------------------------------------------------
  // Power sequencer
  // --------------------------------------------------------------------------
  // Pulse bits: 6 stop ignored, 5 wdt reset, 4 wdt irq, 3 vector, 2 resume.
  always_comb begin
    state_next = state_reg;
    mode_next  = mode_reg;
    src_next   = src_reg;
    presc_next = presc_reg + `LPMC_PRESC_W'(1);
    bit_next   = bit_tick ? bit_reg + 8'h01 : bit_reg;
    t0_next    = t0_reg;
    pulse_next = 5'h00;
    unique case (state_reg)
      LPMC_ST_RUN: begin
        if (stop_exec_i) begin
          if (irq_pending_i) begin
            pulse_next[6] = 1'b1;
          end else begin
            state_next = LPMC_ST_SLEEP;
            t0_next    = 16'h0000;
            if (ccr_reg[`LPMC_CCR_WAKE_BIT]) begin
              mode_next = LPMC_MODE_WAKE;
            end else if (ccr_reg[`LPMC_CCR_RC_WATCHDOG_SELECT_BIT]) begin
              mode_next = LPMC_MODE_RC_WATCHDOG_SELECT;
            end else begin
              mode_next = LPMC_MODE_FULL;
            end
          end
        end
      end
      LPMC_ST_SLEEP: begin
        if (mode_reg != LPMC_MODE_WAKE) begin
          presc_next = presc_reg;
        end
        // Only the 2048 tap feeds timer0; the interval timer stays still.
        bit_next = bit_reg;
        if ((mode_reg == LPMC_MODE_WAKE) && tick2048) begin
          t0_next = t0_ovf ? 16'h0000 : t0_reg + 16'h0001;
        end
        if (wake_any) begin
          src_next = {wdt_bus.match && (mode_reg == LPMC_MODE_RC_WATCHDOG_SELECT), t0_ovf, hit[1], hit[0]};
          // No stabilisation wait for wake-timer mode.
          if (mode_reg == LPMC_MODE_WAKE) begin
            state_next = LPMC_ST_RUN;
          end else begin
            state_next = LPMC_ST_WAIT;
            presc_next = '0;
            bit_next   = 8'h00;
          end
        end
      end
      LPMC_ST_WAIT: begin
        if (bit_ovf) begin
          state_next = LPMC_ST_RUN;
        end
      end
    endcase
    // Release happens when the sequencer re-enters the running state.
    if ((state_reg != LPMC_ST_RUN) && (state_next == LPMC_ST_RUN)) begin
      // Vector or resume by interrupt flag.
      if (i_flag_i) begin
        pulse_next[3] = 1'b1;
        if (src_next[3]) begin
          if (ccr_reg[`LPMC_CCR_WDTRST_BIT]) begin
            pulse_next[5] = 1'b1;
          end else if (ieh_reg[`LPMC_IEH_WDTIE_BIT]) begin
            pulse_next[4] = 1'b1;
          end
        end
      end else begin
        pulse_next[2] = 1'b1;
      end
    end
  end

  // --------------------------------------------------------------------------
  // Clock gating outputs
  // --------------------------------------------------------------------------
  // Bits: 5 halt, 4 oscillator, 3 prescaler, 2 tap only, 1 timer0, 0 RC.
  always_comb begin
    en_next = 6'b011010;
    if (state_next == LPMC_ST_SLEEP) begin
      unique case (mode_next)
        LPMC_MODE_FULL:  en_next = 6'b100000;
        // Oscillator, 2048 tap and timer0 keep going.
        LPMC_MODE_WAKE:  en_next = 6'b111110;
        LPMC_MODE_RC_WATCHDOG_SELECT: en_next = 6'b100001;
      endcase
    end else if (state_next == LPMC_ST_WAIT) begin
      en_next = 6'b111000;
    end
  end

  always_ff @(posedge mclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      state_reg <= LPMC_ST_RUN;
      mode_reg  <= LPMC_MODE_FULL;
      src_reg   <= 4'h0;
      presc_reg <= '0;
      bit_reg   <= 8'h00;
      t0_reg    <= 16'h0000;
      pulse_reg <= 5'h00;
      en_reg    <= 6'b011010;
    end else begin
      state_reg <= state_next;
      mode_reg  <= mode_next;
      src_reg   <= src_next;
      presc_reg <= presc_next;
      bit_reg   <= bit_next;
      t0_reg    <= t0_next;
      pulse_reg <= pulse_next;
      en_reg    <= en_next;
    end
  end

  // --------------------------------------------------------------------------
  // Outputs
  // --------------------------------------------------------------------------
  // Halt keeps CPU, RAM and port latches frozen.
  // The core keeps its program counter while halted.
  assign cpu_halt_o        = en_reg[5];
  assign main_osc_en_o     = en_reg[4];
  assign prescaler_en_o    = en_reg[3];
  assign presc_2048_only_o = en_reg[2];
  assign timer0_en_o       = en_reg[1];
  assign rc_osc_en_o       = en_reg[0];
  assign stop_ignored_o    = pulse_reg[6];
  assign wdt_reset_o       = pulse_reg[5];
  assign wdt_irq_o         = pulse_reg[4];
  assign irq_vector_o      = pulse_reg[3];
  assign resume_o          = pulse_reg[2];
  assign mode_o            = mode_reg;
  assign reg_rdata_o       = rdata_reg;

endmodule : lpmc_top

/* rtl/lpmc_map.svh */
`ifndef LPMC_MAP_SVH
`define LPMC_MAP_SVH

// ----------------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------------
`define LPMC_OFF_CLK_CTL     8'h00
`define LPMC_OFF_IRQ_EN_HI   8'h01
`define LPMC_OFF_WDT_DATA    8'h02
`define LPMC_OFF_T0_CMP      8'h03
`define LPMC_OFF_T1_CMP      8'h04
`define LPMC_OFF_EDGE_SEL    8'h05
`define LPMC_OFF_STATUS      8'h06
`define LPMC_OFF_WAKE_SRC    8'h07

// ----------------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------------
`define LPMC_CCR_WAKE_BIT    6
`define LPMC_CCR_RC_WATCHDOG_SELECT_BIT   5
`define LPMC_CCR_WDTRST_BIT  4
`define LPMC_CCR_CASCADE_BIT 3
`define LPMC_CCR_BITSEL_HI   2
`define LPMC_CCR_BITSEL_LO   0
`define LPMC_IEH_WDTIE_BIT   0
`define LPMC_WDT_CLEAR_BIT   7
`define LPMC_STS_WDTFLAG_BIT 6

// ----------------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------------
`define LPMC_RST_CLK_CTL     8'h00
`define LPMC_RST_IRQ_EN_HI   8'h00
`define LPMC_RST_WDT_DATA    7'h7f
`define LPMC_RST_T0_CMP      8'hff
`define LPMC_RST_T1_CMP      8'h00
`define LPMC_RST_EDGE_SEL    4'h5

// ----------------------------------------------------------------------------
// Timing counts
// ----------------------------------------------------------------------------
`define LPMC_PRESC_W         12
`define LPMC_DIV2048_TOP     11'h7ff
`define LPMC_BIT_TOP         8'hff

`endif

/* rtl/lpmc_pkg.sv */
package lpmc_pkg;

  typedef enum logic [2:0] {
    LPMC_ST_RUN   = 3'b001,
    LPMC_ST_SLEEP = 3'b010,
    LPMC_ST_WAIT  = 3'b100
  } lpmc_state_t;

  typedef enum logic [2:0] {
    LPMC_MODE_FULL  = 3'b001,
    LPMC_MODE_WAKE  = 3'b010,
    LPMC_MODE_RC_WATCHDOG_SELECT = 3'b100
  } lpmc_mode_t;

endpackage : lpmc_pkg

/* rtl/lpmc_wdt_if.sv */
`timescale 1ns/1ps

interface lpmc_wdt_if;
  logic       tick;
  logic       clear;
  logic [6:0] limit;
  logic       match;

  modport ctl (output tick, output clear, output limit, input match);
  modport wdt (input tick, input clear, input limit, output match);
endinterface : lpmc_wdt_if

/* rtl/lpmc_watchdog.sv */
`timescale 1ns/1ps

module lpmc_watchdog (
  input  wire logic mclk_i,
  input  wire logic sys_rst_i,
  lpmc_wdt_if.wdt   wdt
);
  import lpmc_pkg::*;

  logic [6:0] cnt_reg;
  logic [6:0] cnt_next;
  logic       match_reg;
  logic       match_next;

  // --------------------------------------------------------------------------
  // Seven-bit counter
  // --------------------------------------------------------------------------
  always_comb begin
    cnt_next   = cnt_reg;
    match_next = 1'b0;
    if (wdt.clear) begin
      cnt_next = 7'h00;
    end else if (wdt.tick) begin
      if (cnt_reg == wdt.limit) begin
        match_next = 1'b1;
        cnt_next   = 7'h00;
      end else begin
        cnt_next = cnt_reg + 7'h01;
      end
    end
  end

  always_ff @(posedge mclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      cnt_reg   <= 7'h00;
      match_reg <= 1'b0;
    end else begin
      cnt_reg   <= cnt_next;
      match_reg <= match_next;
    end
  end

  assign wdt.match = match_reg;

endmodule : lpmc_watchdog

/* tb/lpmc_monitor.sv */
`timescale 1ns/1ps
module lpmc_monitor
  import lpmc_pkg::*;
(
  input wire logic                 mclk_i,
  input wire logic                 sys_rst_i,
  input wire logic                 stop_exec_i,
  input wire logic                 irq_pending_i,
  input wire logic                 cpu_halt_o,
  input wire logic                 main_osc_en_o,
  input wire logic                 prescaler_en_o,
  input wire logic                 presc_2048_only_o,
  input wire logic                 timer0_en_o,
  input wire logic                 rc_osc_en_o,
  input wire logic                 resume_o,
  input wire logic                 irq_vector_o,
  input wire logic                 wdt_irq_o,
  input wire logic                 wdt_reset_o,
  input wire logic                 stop_ignored_o,
  input wire lpmc_pkg::lpmc_mode_t mode_o
);
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (sys_rst_i);
  logic [15:0] wait_cnt_reg;
  logic [15:0] wait_cnt_next;
  // Length of the current stabilisation wait, so the release can be judged.
  always_comb begin
    wait_cnt_next = (cpu_halt_o && main_osc_en_o && !presc_2048_only_o) ? wait_cnt_reg + 16'h0001
                                                                         : 16'h0000;
  end
  always_ff @(posedge mclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      wait_cnt_reg <= 16'h0000;
    end else begin
      wait_cnt_reg <= wait_cnt_next;
    end
  end
  chk_stop_enter: assert property (stop_exec_i && !irq_pending_i && !cpu_halt_o
    |=> cpu_halt_o && !stop_ignored_o) else $error("stop did not halt");
  chk_stop_refuse: assert property (stop_exec_i && irq_pending_i && !cpu_halt_o
    |=> stop_ignored_o && !cpu_halt_o) else $error("pending stop not refused");
  chk_full_gates: assert property (cpu_halt_o && !main_osc_en_o && mode_o == LPMC_MODE_FULL
    |-> !prescaler_en_o && !timer0_en_o && !rc_osc_en_o) else $error("full stop gating");
  chk_wake_gates: assert property (cpu_halt_o && mode_o == LPMC_MODE_WAKE
    |-> main_osc_en_o && presc_2048_only_o && timer0_en_o && !rc_osc_en_o)
    else $error("wake mode gating");
  chk_rc_gates: assert property (cpu_halt_o && !main_osc_en_o && mode_o == LPMC_MODE_RC_WATCHDOG_SELECT
    |-> rc_osc_en_o && !prescaler_en_o && !timer0_en_o) else $error("rc mode gating");
  chk_wake_direct: assert property ($fell(cpu_halt_o) && mode_o == LPMC_MODE_WAKE
    |-> $past(presc_2048_only_o)) else $error("wake mode went through a wait");
  chk_stab_wait: assert property ($fell(cpu_halt_o) && mode_o != LPMC_MODE_WAKE
    |-> wait_cnt_reg >= 16'd510) else $error("stabilisation wait too short");
  chk_release_pulse: assert property ($fell(cpu_halt_o)
    |-> ##[0:1] (resume_o || irq_vector_o)) else $error("release without pulse");
  chk_wdt_pair: assert property (wdt_reset_o || wdt_irq_o
    |-> irq_vector_o && !(wdt_reset_o && wdt_irq_o)) else $error("watchdog pulse misuse");
endmodule : lpmc_monitor

/* tb/lpmc_cpu_model.sv */
`timescale 1ns/1ps
module lpmc_cpu_model (
  input  wire logic mclk_i,
  input  wire logic sys_rst_i,
  input  wire logic stop_req_i,
  input  wire logic pend_req_i,
  input  wire logic ie_req_i,
  output logic      stop_exec_o,
  output logic      irq_pending_o,
  output logic      i_flag_o
);
  logic [1:0] nop_reg;
  always_ff @(posedge mclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      stop_exec_o   <= 1'b0;
      irq_pending_o <= 1'b0;
      i_flag_o      <= 1'b0;
      nop_reg       <= 2'h0;
    end else begin
      // Two no-op cycles follow each stop.
      stop_exec_o <= stop_req_i && nop_reg == 2'h0;
      nop_reg     <= (stop_req_i && nop_reg == 2'h0) ? 2'h2 : nop_reg - {1'b0, nop_reg != 2'h0};
      irq_pending_o <= pend_req_i;
      i_flag_o      <= ie_req_i;
    end
  end
endmodule : lpmc_cpu_model

/* tb/lpmc_top_bench.sv */
`timescale 1ns/1ps
`include "lpmc_map.svh"
module lpmc_top_bench;
  import lpmc_pkg::*;
  logic       mclk_i = 0, sys_rst_i = 1, reg_wr_i = 0, reg_rd_i = 0, rc_clk_i = 0;
  logic       ext_irq_zero_i = 0, ext_irq_one_i = 0, stop_req = 0, pend_req = 0, ie_req = 0;
  logic [7:0] reg_addr_i = 0, reg_wdata_i = 0, reg_rdata_o, v, ccr;
  logic       stop_exec_i, irq_pending_i, i_flag_i, cpu_halt_o, main_osc_en_o, prescaler_en_o;
  logic       presc_2048_only_o, timer0_en_o, rc_osc_en_o, resume_o, irq_vector_o, clr = 0;
  logic       wdt_irq_o, wdt_reset_o, stop_ignored_o;
  logic [4:0] seen;
  lpmc_mode_t mode_o;
  int         fail_count = 0, cmp_count = 0, n, c, p;
  logic [7:0] ra[6] = '{8'h00, 8'h01, 8'h03, 8'h04, 8'h05, 8'h30};
  logic [7:0] re[6] = '{8'h00, 8'h00, 8'hff, 8'h00, 8'h05, 8'h00};
  lpmc_top DUT (.mclk_i, .sys_rst_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i,
    .reg_rdata_o, .stop_exec_i, .irq_pending_i, .i_flag_i, .ext_irq_zero_i, .ext_irq_one_i,
    .rc_clk_i, .cpu_halt_o, .main_osc_en_o, .prescaler_en_o, .presc_2048_only_o, .timer0_en_o,
    .rc_osc_en_o, .resume_o, .irq_vector_o, .wdt_irq_o, .wdt_reset_o, .stop_ignored_o, .mode_o);
  lpmc_cpu_model u_cpu (.mclk_i, .sys_rst_i, .stop_req_i(stop_req), .pend_req_i(pend_req),
    .ie_req_i(ie_req), .stop_exec_o(stop_exec_i), .irq_pending_o(irq_pending_i),
    .i_flag_o(i_flag_i));
  initial forever #10 mclk_i = ~mclk_i;
  initial forever #67 rc_clk_i = ~rc_clk_i;
  // Sticky record of the pulse outputs, stop ignored included, since they stand for one cycle only.
  always @(posedge mclk_i) begin
    seen <= clr ? 5'h00 : seen | {stop_ignored_o, wdt_reset_o, wdt_irq_o, irq_vector_o, resume_o};
  end
  function automatic lpmc_mode_t exp_mode(input logic [7:0] r);
    return r[6] ? LPMC_MODE_WAKE : (r[5] ? LPMC_MODE_RC_WATCHDOG_SELECT : LPMC_MODE_FULL);
  endfunction : exp_mode
  function automatic logic [4:0] exp_seen(input logic ie, input logic [1:0] wd);
    return {1'b0, wd, ie, !ie};
  endfunction : exp_seen
  task automatic close_out();
    if (fail_count == 0 && cmp_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : close_out
  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    cmp_count++;
    if (g !== e) begin
      fail_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk_i);
    reg_wr_i <= 1; reg_addr_i <= a; reg_wdata_i <= d;
    @(posedge mclk_i);
    reg_wr_i <= 0;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge mclk_i);
    reg_rd_i <= 1; reg_addr_i <= a;
    @(posedge mclk_i);
    reg_rd_i <= 0;
    #1 d = reg_rdata_o;
  endtask : rd
  task automatic go_stop(input logic ie);
    @(posedge mclk_i);
    clr <= 1; ie_req <= ie;
    @(posedge mclk_i);
    clr <= 0; stop_req <= 1;
    @(posedge mclk_i);
    stop_req <= 0;
    repeat (3) @(posedge mclk_i);
    #1;
  endtask : go_stop
  task automatic wait_run(input int lim);
    n = 0;
    while (cpu_halt_o !== 1'b0 && n < lim) begin
      @(posedge mclk_i);
      #1;
      n++;
    end
    if (n >= lim) begin
      fail_count++;
      close_out();
    end
    repeat (2) @(posedge mclk_i);
    #1;
  endtask : wait_run
  initial begin
    void'($urandom(32'h2aa5));
    repeat (4) @(posedge mclk_i);
    sys_rst_i <= 0;
    for (int i = 0; i < 6; i++) begin
      rd(ra[i], v);
      chk(v, re[i]);
    end
    @(posedge mclk_i);
    pend_req <= 1;
    go_stop(0);
    chk({cpu_halt_o, seen}, 6'h10);
    pend_req <= 0;
    // Whole-byte writes with the 2048 tap feeding timer0.
    // The cascade bit may be set; the upper compare byte stays zero so the run stays short.
    for (int k = 0; k < 2; k++) begin
      c = $urandom % 3;
      ccr = 8'h40 | (8'($urandom) & 8'h2f);
      wr(`LPMC_OFF_T0_CMP, 8'(c));
      wr(`LPMC_OFF_CLK_CTL, ccr);
      go_stop(k[0]);
      chk({cpu_halt_o, 3'(mode_o)}, {1'b1, 3'(exp_mode(ccr))});
      wait_run(8000);
      chk(16'(n + 8 > c * 2048 && n < c * 2048 + 2060), 16'h0001);
      chk(seen, exp_seen(k[0], 2'b00));
    end
    ccr = 8'h00 | (8'($urandom) & 8'h01);
    p = $urandom % 2;
    wr(`LPMC_OFF_CLK_CTL, ccr);
    go_stop(p[0]);
    chk({cpu_halt_o, 3'(mode_o)}, {1'b1, 3'(exp_mode(ccr))});
    repeat (300) @(posedge mclk_i);
    ext_irq_zero_i <= !p[0];
    ext_irq_one_i <= p[0];
    #1 chk(cpu_halt_o, 1'b1);
    wait_run(3000);
    chk(seen, exp_seen(p[0], 2'b00));
    rd(`LPMC_OFF_CLK_CTL, v);
    chk(v, ccr);
    rd(`LPMC_OFF_WAKE_SRC, v);
    chk(v, p[0] ? 8'h02 : 8'h01);
    @(posedge mclk_i);
    ext_irq_zero_i <= 0;
    ext_irq_one_i <= 0;
    for (int k = 0; k < 2; k++) begin
      ccr = 8'h20 | 8'(k << 4);
      wr(`LPMC_OFF_IRQ_EN_HI, 8'h01);
      wr(`LPMC_OFF_WDT_DATA, 8'h82);
      wr(`LPMC_OFF_STATUS, 8'h40);
      wr(`LPMC_OFF_CLK_CTL, ccr);
      go_stop(1);
      chk({cpu_halt_o, 3'(mode_o)}, {1'b1, 3'(exp_mode(ccr))});
      wait_run(5000);
      chk(seen, exp_seen(1, k[0] ? 2'b10 : 2'b01));
      rd(`LPMC_OFF_STATUS, v);
      chk(v, {2'b01, 3'(LPMC_MODE_RC_WATCHDOG_SELECT), 3'(LPMC_ST_RUN)});
      rd(`LPMC_OFF_WAKE_SRC, v);
      chk(v, 8'h08);
    end
    // A reset in the middle of a full stop must wake the core and reload the clock control register.
    wr(`LPMC_OFF_CLK_CTL, 8'h07);
    go_stop(0);
    chk({cpu_halt_o, 3'(mode_o)}, {1'b1, 3'(LPMC_MODE_FULL)});
    @(posedge mclk_i);
    sys_rst_i <= 1;
    repeat (2) @(posedge mclk_i);
    sys_rst_i <= 0;
    #1 chk({cpu_halt_o, 3'(mode_o)}, {1'b0, 3'(LPMC_MODE_FULL)});
    rd(`LPMC_OFF_CLK_CTL, v);
    chk(v, `LPMC_RST_CLK_CTL);
    close_out();
  end
endmodule : lpmc_top_bench
bind lpmc_top lpmc_monitor u_mon (.mclk_i, .sys_rst_i, .stop_exec_i, .irq_pending_i, .cpu_halt_o,
  .main_osc_en_o, .prescaler_en_o, .presc_2048_only_o, .timer0_en_o, .rc_osc_en_o, .resume_o,
  .irq_vector_o, .wdt_irq_o, .wdt_reset_o, .stop_ignored_o, .mode_o);
